// >>> inc/csed_pkg.sv
// Constants and carriers for the CAN status and error diagnostic block.
// Assumes one 20 MHz clock and a classic Wishbone slave with 32-bit data.
// Behaviour
// - Node state reported as coded 3-bit field
// - Flag and code name top enabled pending
// - Code 0 error, 1 to 15 buffers
// - Both error counters readable in one register
// - Read-only diagnostic register, cleared by reset
// - Last error frame field kept as code
// - Bit index loads length-1, counts down
// - Transmitter flag set when we were sending
// - Stuff flag records stuffing violation
// - CRC flag kept as reported, with any field code
// - Receive level captured at error time
// - Transmit pin value captured at error time
// - Free-running 16-bit bit counter from zero
// - Stamp enable clears counter on buffer 0
// - Counter copied into buffer stamp on transfer
// - Disable also blocks the receive pin
// - Register contents kept across low power
// - Pin polarities follow two configuration bits
// - Only enabled sources enter the code
package csed_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CFG  = 8'h00;
	localparam logic [7:0] OFS_CEN  = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_EC   = 8'h0C;
	localparam logic [7:0] OFS_DIAG = 8'h10;
	localparam logic [7:0] OFS_CTR  = 8'h14;

	// Global configuration bit positions
	localparam int CFG_EN    = 0;
	localparam int CFG_TXPOL = 1;
	localparam int CFG_RXPOL = 2;
	localparam int CFG_STAMP = 3;

	// Reset values
	localparam logic [3:0]  CFG_RST  = 4'h0;
	localparam logic [15:0] CEN_RST  = 16'h0000;
	localparam logic [15:0] CTR_RST  = 16'h0000;
	localparam logic [5:0]  IDX_RST  = 6'h00;

	// Node state codes
	localparam logic [2:0] NS_OFF  = 3'h0;
	localparam logic [2:0] NS_ACT  = 3'h2;
	localparam logic [2:0] NS_WARN = 3'h3;
	localparam logic [2:0] NS_PASS = 3'h4;
	localparam logic [2:0] NS_BOFF = 3'h6;

	// Error counter thresholds
	localparam logic [7:0] WARN_LIM = 8'h60;
	localparam logic [7:0] PASS_LIM = 8'h80;

	// Status field positions
	localparam int ST_CODE = 0;
	localparam int ST_REQ  = 4;
	localparam int ST_NS   = 5;

	// Frame field code of the acknowledge slot
	localparam logic [3:0] FLD_ACK = 4'h4;

	// Diagnostic register layout, bit 15 reads zero
	typedef struct packed {
		logic       drive;
		logic       mon;
		logic       crc;
		logic       stuff;
		logic       was_transmitter;
		logic [5:0] bit_idx;
		logic [3:0] field;
	} csed_diag_s;

	// Error event from the protocol engine
	typedef struct packed {
		logic valid;
		logic stuff;
		logic crc;
	} csed_err_s;

	// Start of a frame field
	typedef struct packed {
		logic       start;
		logic [3:0] code;
		logic [6:0] len;
	} csed_field_s;

	// Completed transfer of one message buffer
	typedef struct packed {
		logic       done;
		logic [3:0] buf_idx;
	} csed_xfer_s;

endpackage

// >>> core/csed_irq_enc.sv
// Registered priority encoder for the interrupt source code.
// Assumes pending and enable vectors on the same clock, error bit on top.
`timescale 1ns/1ps
`default_nettype none
module csed_irq_enc #(
	parameter int NBUF = 15
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic [NBUF:0]   pend_i,
	input  wire logic [NBUF:0]   en_i,
	output logic                 req_o,
	output logic [3:0]           code_o
);
	logic [NBUF:0] hit;
	logic          nxt_req;
	logic [3:0]    nxt_code;

	if (NBUF > 15 || NBUF < 1) begin : g_chk
		$error("csed_irq_enc: NBUF must be 1 to 15");
	end

	// Lowest buffer wins, error overrides all
	always_comb begin
		hit = pend_i & en_i;
		nxt_req = 1'b0;
		nxt_code = 4'h0;
		for (int i = NBUF - 1; i >= 0; i--) begin
			if (hit[i]) begin
				nxt_req = 1'b1;
				nxt_code = 4'(i + 1);
			end
		end
		if (hit[NBUF]) begin
			nxt_req = 1'b1;
			nxt_code = 4'h0;
		end
	end

	// Code register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_o <= 1'b0;
			code_o <= 4'h0;
		end else begin
			req_o <= nxt_req;
			code_o <= nxt_code;
		end
	end
endmodule // csed_irq_enc
`default_nettype wire

// >>> core/csed_core.sv
// CAN status, interrupt code, error counters, diagnostics, bit counter and pins.
// Assumes a protocol engine on clk_i and a transceiver on the two bus pins.
`timescale 1ns/1ps
`default_nettype none
module csed_core #(
	parameter int NBUF = 15
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone classic slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic                      wb_ack_o,
	output logic [31:0]               wb_dat_o,
	// Protocol engine side
	input  wire logic                 bit_tick_i,
	input  wire logic                 tx_bit_i,
	input  wire logic                 was_tx_i,
	input  wire logic [7:0]           rec_i,
	input  wire logic [7:0]           tec_i,
	input  wire logic                 bus_off_i,
	input  wire logic [NBUF:0]        pend_i,
	input  wire csed_pkg::csed_field_s field_i,
	input  wire csed_pkg::csed_err_s  err_i,
	input  wire csed_pkg::csed_xfer_s xfer_i,
	output logic                      ctrl_en_o,
	output logic                      rx_bit_o,
	output logic                      stamp_we_o,
	output logic [3:0]                stamp_buf_o,
	output logic [15:0]               stamp_val_o,
	// Transceiver pins
	input  wire logic                 bus_rx_pin_i,
	output logic                      bus_tx_pin_o
);
	import csed_pkg::*;

	if (NBUF > 15 || NBUF < 1) begin : g_chk
		$error("csed_core: NBUF must be 1 to 15");
	end

	logic [3:0]  cfg_ff;
	logic [15:0] cen_ff;
	logic [2:0]  ns_ff;
	logic [2:0]  nxt_ns;
	logic        irq_req;
	logic [3:0]  irq_code;
	logic [5:0]  idx_ff;
	logic [3:0]  cur_field_ff;
	csed_diag_s  diag_ff;
	logic [15:0] ctr_ff;
	logic        ctr_clr;
	logic        rx_meta_ff;
	logic        rx_sync_ff;
	logic        wb_req;
	logic        wb_wr;
	logic [31:0] rd_data;
	logic [15:0] cen_full;

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------

	// Ack one cycle after request, dropped the cycle after
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge where the master samples ack
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			OFS_CFG:  rd_data[3:0] = cfg_ff;
			OFS_CEN:  rd_data[15:0] = cen_ff;
			OFS_STAT: begin
				rd_data[ST_CODE +: 4] = irq_code;
				rd_data[ST_REQ] = irq_req;
				rd_data[ST_NS +: 3] = ns_ff;
			end
			OFS_EC:   rd_data[15:0] = {rec_i, tec_i};
			OFS_DIAG: rd_data[15:0] = {1'b0, diag_ff};
			OFS_CTR:  rd_data[15:0] = ctr_ff;
			default:  rd_data = 32'h0000_0000;
		endcase
	end

	// Read data captured with the request, held through ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req) begin
			wb_dat_o <= rd_data;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------

	// Only reset clears them; disable and low power leave them intact
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= CFG_RST;
		end else if (wb_wr && wb_adr_i == OFS_CFG && wb_sel_i[0]) begin
			cfg_ff <= wb_dat_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cen_ff <= CEN_RST;
		end else if (wb_wr && wb_adr_i == OFS_CEN) begin
			if (wb_sel_i[0]) begin
				cen_ff[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				cen_ff[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_en_o <= 1'b0;
		end else begin
			ctrl_en_o <= cfg_ff[CFG_EN];
		end
	end

	// ------------------------------------------------------------
	// Node state and interrupt code
	// ------------------------------------------------------------

	// Disable dominates, then bus off, then the counter thresholds
	always_comb begin
		if (!cfg_ff[CFG_EN]) begin
			nxt_ns = NS_OFF;
		end else if (bus_off_i) begin
			nxt_ns = NS_BOFF;
		end else if (rec_i >= PASS_LIM || tec_i >= PASS_LIM) begin
			nxt_ns = NS_PASS;
		end else if (rec_i >= WARN_LIM || tec_i >= WARN_LIM) begin
			nxt_ns = NS_WARN;
		end else begin
			nxt_ns = NS_ACT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ns_ff <= NS_OFF;
		end else begin
			ns_ff <= nxt_ns;
		end
	end

	// Error enable sits at bit 15, buffers in the low bits
	assign cen_full = cen_ff;

	csed_irq_enc #(
		.NBUF (NBUF)
	) u_enc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pend_i (pend_i),
		.en_i   ({cen_full[15], cen_full[NBUF-1:0]}),
		.req_o  (irq_req),
		.code_o (irq_code)
	);

	// ------------------------------------------------------------
	// Receive and transmit pins
	// ------------------------------------------------------------

	// Two-stage synchroniser on the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
		end else begin
			rx_meta_ff <= bus_rx_pin_i;
			rx_sync_ff <= rx_meta_ff;
		end
	end

	// Disabled controller sees a recessive bus, so no false wake-up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_bit_o <= 1'b1;
		end else if (!cfg_ff[CFG_EN]) begin
			rx_bit_o <= 1'b1;
		end else begin
			rx_bit_o <= rx_sync_ff ^ cfg_ff[CFG_RXPOL];
		end
	end

	// Recessive level while disabled, polarity applied always
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_tx_pin_o <= 1'b1;
		end else begin
			bus_tx_pin_o <= (tx_bit_i | ~cfg_ff[CFG_EN]) ^ cfg_ff[CFG_TXPOL];
		end
	end

	// ------------------------------------------------------------
	// Error diagnostics
	// ------------------------------------------------------------

	// Field index: load length-1 at field start, count down per bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_ff <= IDX_RST;
			cur_field_ff <= 4'h0;
		end else if (field_i.start) begin
			idx_ff <= 6'(field_i.len - 7'h01);
			cur_field_ff <= field_i.code;
		end else if (bit_tick_i) begin
			idx_ff <= idx_ff - 6'h01;
		end
	end

	// Snapshot of the erroneous bit, values as they stood at the error
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diag_ff <= '0;
		end else if (err_i.valid) begin
			diag_ff.field <= cur_field_ff;
			diag_ff.bit_idx <= idx_ff;
			diag_ff.was_transmitter <= was_tx_i;
			diag_ff.stuff <= err_i.stuff;
			diag_ff.crc <= err_i.crc;
			diag_ff.mon <= rx_bit_o;
			diag_ff.drive <= bus_tx_pin_o;
		end
	end

	// ------------------------------------------------------------
	// Bit counter and time stamps
	// ------------------------------------------------------------

	// Buffer 0 transfer restarts the count when stamping is on
	assign ctr_clr = cfg_ff[CFG_STAMP] & xfer_i.done & (xfer_i.buf_idx == 4'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctr_ff <= CTR_RST;
		end else if (ctr_clr) begin
			ctr_ff <= CTR_RST;
		end else if (bit_tick_i) begin
			ctr_ff <= ctr_ff + 16'h0001;
		end
	end

	// Stamp takes the count before any clear of the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stamp_we_o <= 1'b0;
			stamp_buf_o <= 4'h0;
			stamp_val_o <= 16'h0000;
		end else begin
			stamp_we_o <= xfer_i.done;
			if (xfer_i.done) begin
				stamp_buf_o <= xfer_i.buf_idx;
				stamp_val_o <= ctr_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ns_disabled_a: assert property (!cfg_ff[CFG_EN] |=> ns_ff == NS_OFF)
		else $error("node state not off while disabled");
	ns_busoff_a: assert property (cfg_ff[CFG_EN] && bus_off_i |=> ns_ff == NS_BOFF)
		else $error("bus off not reported");
	err_code_a: assert property (
		pend_i[NBUF] && cen_ff[15] |=> irq_req && irq_code == 4'h0)
		else $error("error interrupt not ranked first");
	buf0_code_a: assert property (
		pend_i[0] && cen_ff[0] && !(pend_i[NBUF] && cen_ff[15])
		|=> irq_req && irq_code == 4'h1)
		else $error("buffer 0 code wrong");
	no_code_a: assert property (
		(pend_i & {cen_ff[15], cen_ff[NBUF-1:0]}) == '0
		|=> !irq_req && irq_code == 4'h0)
		else $error("code shown for disabled source");
	idx_load_a: assert property (
		field_i.start |=> idx_ff == 6'($past(field_i.len) - 7'h01))
		else $error("bit index not loaded");
	diag_cap_a: assert property (
		err_i.valid |=> diag_ff.field == $past(cur_field_ff)
		&& diag_ff.bit_idx == $past(idx_ff) && diag_ff.was_transmitter == $past(was_tx_i))
		else $error("diagnostic capture wrong");
	// Error flags as the engine reported them in the error cycle
	diag_flags_a: assert property (
		err_i.valid |=> diag_ff.stuff == $past(err_i.stuff)
		&& diag_ff.crc == $past(err_i.crc))
		else $error("diagnostic error flags wrong");
	// Pin levels as they stood in the error cycle, not one later
	diag_pins_a: assert property (
		err_i.valid |=> diag_ff.mon == $past(rx_bit_o)
		&& diag_ff.drive == $past(bus_tx_pin_o))
		else $error("diagnostic pin levels wrong");
	// Only an error event may touch the snapshot
	diag_hold_a: assert property (!err_i.valid |=> $stable(diag_ff))
		else $error("diagnostic changed without error");
	ctr_inc_a: assert property (
		bit_tick_i && !ctr_clr |=> ctr_ff == $past(ctr_ff) + 16'h0001)
		else $error("bit counter did not count");
	ctr_clear_a: assert property (ctr_clr |=> ctr_ff == 16'h0000)
		else $error("bit counter not cleared");
	stamp_copy_a: assert property (
		xfer_i.done |=> stamp_we_o && stamp_val_o == $past(ctr_ff))
		else $error("time stamp not copied");
	rx_block_a: assert property (!cfg_ff[CFG_EN] |=> rx_bit_o)
		else $error("receive pin not blocked");
	tx_pol_a: assert property (
		cfg_ff[CFG_EN] |=> bus_tx_pin_o == ($past(tx_bit_i) ^ $past(cfg_ff[CFG_TXPOL])))
		else $error("transmit polarity wrong");

	err_seen_c: cover property (err_i.valid && was_tx_i && err_i.stuff);
	stamp_clr_c: cover property (ctr_clr ##1 stamp_we_o);
	code_buf_c: cover property (irq_req && irq_code == 4'hF);
	boff_state_c: cover property (ns_ff == NS_BOFF);
endmodule // csed_core
`default_nettype wire

// >>> verification/csed_xcvr_model.sv
// Stand-in for the external bus transceiver on the two controller pins.
// Assumes pin level 0 is dominant on the wire and the bus is wired-AND.
`timescale 1ns/1ps
`default_nettype none
module csed_xcvr_model (
	input  wire logic tx_pin_i,
	input  wire logic remote_dom_i,
	output logic      rx_pin_o
);
	// ----------------------------------------
	// Wire level
	// ----------------------------------------
	// Own drive echoes back; a remote dominant bit always wins
	assign rx_pin_o = tx_pin_i & ~remote_dom_i;
endmodule // csed_xcvr_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the status, code, counter and diagnostic block.
// Assumes the transceiver model and a classic Wishbone master run by this bench.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import csed_pkg::*;
	// ----------------------------------------
	// Stimulus, design and far side
	// ----------------------------------------
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tick = 0;
	logic        txb = 1, wtx = 0, boff = 0, rdom = 0;
	logic        ack, txp, rxp, rxb, swe, cen;
	logic [7:0]  adr = 8'h00, receive_error_count = 8'h00, transmit_error_count = 8'h00;
	logic [3:0]  sel = 4'hf, sbuf;
	logic [15:0] pend = 16'h0000, en16, sval;
	logic [31:0] wdat = 32'h0000_0000, rd, dat_o, lf = 32'h0000_4b24;
	logic [31:0] dexp;
	csed_field_s fld = '0;
	csed_err_s   er = '0;
	csed_xfer_s  xf = '0;
	int          err_total = 0, n_checks = 0, cyc_n = 0, ln, k;
	logic [7:0]  ofs [7] = '{OFS_CFG, OFS_CEN, OFS_STAT, OFS_EC, OFS_DIAG, OFS_CTR, 8'h18};
	logic [7:0]  lim [4] = '{8'h5f, 8'h60, 8'h7f, 8'h80};

	csed_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
		.wb_dat_o(dat_o), .bit_tick_i(tick), .tx_bit_i(txb), .was_tx_i(wtx), .rec_i(receive_error_count),
		.tec_i(transmit_error_count), .bus_off_i(boff), .pend_i(pend), .field_i(fld), .err_i(er),
		.xfer_i(xf), .ctrl_en_o(cen), .rx_bit_o(rxb), .stamp_we_o(swe),
		.stamp_buf_o(sbuf), .stamp_val_o(sval), .bus_rx_pin_i(rxp), .bus_tx_pin_o(txp));
	csed_xcvr_model u_xcvr (.tx_pin_i(txp), .remote_dom_i(rdom), .rx_pin_o(rxp));

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	// Hang guard, far above the roughly 1300 cycles the run needs
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [2:0] ns_exp(input logic b, input logic [7:0] r, t);
		if (b) return NS_BOFF;
		if (r >= PASS_LIM || t >= PASS_LIM) return NS_PASS;
		if (r >= WARN_LIM || t >= WARN_LIM) return NS_WARN;
		return NS_ACT;
	endfunction

	// Error source first, then the lowest buffer number
	function automatic logic [4:0] irq_exp(input logic [15:0] p, e);
		logic [15:0] m;
		m = p & e;
		if (m[15]) return 5'h10;
		for (int i = 0; i < 15; i++) if (m[i]) return {1'b1, 4'(i + 1)};
		return 5'h00;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// One classic cycle; entered just after a rising edge, leaves one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) err_total++;
		rd = dat_o;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1;
			@(posedge clk_i);
			tick <= 0;
			@(posedge clk_i);
		end
	endtask

	task automatic xfer(input logic [3:0] b, input logic [15:0] v);
		xf <= '{done: 1'b1, buf_idx: b};
		@(posedge clk_i);
		xf.done <= 0;
		@(posedge clk_i);
		chk("stamp", {swe, sbuf, sval}, {1'b1, b, v});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		// Writes to read-only places and a hole must leave no trace
		for (int i = 2; i < 7; i++) wb(1, ofs[i], 32'h0000_ffff);
		foreach (ofs[i]) begin
			wb(0, ofs[i], 0);
			chk("reset value", rd, 0);
		end
		wb(1, OFS_CFG, 32'h0000_0001);
		// Enable output follows the register one edge later
		@(posedge clk_i);
		chk("enable", cen, 1);
		// Node state over threshold corners, then random counters
		for (int i = 0; i < 24; i++) begin
			lf = lfsr_next(lf);
			receive_error_count <= (i < 4) ? lim[i] : lf[7:0];
			transmit_error_count <= (i < 4) ? 8'h00 : lf[15:8];
			boff <= (i == 4) || ((i > 4) && (lf[19:16] == 4'h0));
			@(posedge clk_i);
			wb(0, OFS_EC, 0);
			chk("error counters", rd, {16'h0000, receive_error_count, transmit_error_count});
			wb(0, OFS_STAT, 0);
			chk("node state", rd[7:5], ns_exp(boff, receive_error_count, transmit_error_count));
		end
		// Every source code alone, then random pending and enable mixes
		for (int i = 0; i < 48; i++) begin
			lf = lfsr_next(lf);
			en16 = (i < 16) ? 16'h0001 << i : lf[31:16];
			pend <= (i < 16) ? 16'hffff : (i == 16) ? 16'h0000 : lf[15:0];
			wb(1, OFS_CEN, {16'h0000, en16});
			repeat (2) @(posedge clk_i);
			wb(0, OFS_STAT, 0);
			chk("irq code", rd[4:0], irq_exp(pend, en16));
		end
		// Bit counter, stamp copy, clear only on buffer 0 with stamp enabled
		lf = lfsr_next(lf);
		ln = lf[4:0] + 1;
		ticks(ln);
		wb(0, OFS_CTR, 0);
		chk("bit counter", rd, ln);
		wb(1, OFS_CFG, 32'h0000_0009);
		xfer(4'h0, 16'(ln));
		wb(0, OFS_CTR, 0);
		chk("counter cleared", rd, 0);
		ticks(3);
		xfer(4'h5, 16'h0003);
		wb(1, OFS_CFG, 32'h0000_0001);
		xfer(4'h0, 16'h0003);
		wb(0, OFS_CTR, 0);
		chk("counter kept", rd, 3);
		// Error capture in every field code
		for (int i = 0; i < 16; i++) begin
			lf = lfsr_next(lf);
			ln = lf[5:0] + 1;
			k = lf[13:8] % ln;
			txb <= lf[16];
			wtx <= lf[17];
			repeat (6) @(posedge clk_i);
			fld <= '{start: 1'b1, code: 4'(i), len: 7'(ln)};
			@(posedge clk_i);
			fld.start <= 0;
			ticks(k);
			er <= '{valid: 1'b1, stuff: lf[18], crc: lf[19]};
			@(posedge clk_i);
			er.valid <= 0;
			wb(0, OFS_DIAG, 0);
			dexp = {17'h0, txb, txb, lf[19:18], wtx, 6'(ln - 1 - k), 4'(i)};
			chk("diagnostic", rd, dexp);
		end
		// Pin polarities with a remote dominant bit on the wire
		for (int p = 0; p < 4; p++) begin
			wb(1, OFS_CFG, {29'h0, p[1], p[0], 1'b1});
			txb <= 1;
			rdom <= 1;
			repeat (6) @(posedge clk_i);
			chk("tx pin", txp, !p[0]);
			chk("rx level", rxb, p[1]);
		end
		// Disabled controller blocks the receiver and keeps its settings
		wtx <= 0;
		wb(1, OFS_CFG, 0);
		repeat (5) @(posedge clk_i);
		chk("rx blocked", {rxb, txp, cen}, 3'b110);
		wb(0, OFS_STAT, 0);
		chk("state off", rd[7:5], NS_OFF);
		wb(0, OFS_CEN, 0);
		chk("code enable kept", rd, en16);
		// Wake-up: software switches the controller back on
		wb(1, OFS_CFG, 32'h0000_0001);
		@(posedge clk_i);
		chk("re-enabled", {rxb, cen}, 2'b01);
		// Second reset in mid-run must clear a filled snapshot and counter
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		foreach (ofs[i]) begin
			dexp = (ofs[i] == OFS_EC) ? {16'h0000, receive_error_count, transmit_error_count} : 32'h0000_0000;
			wb(0, ofs[i], 0);
			chk("reset again", rd, dexp);
		end
		wrap_up();
	end
endmodule // tb
`default_nettype wire
